//--- src/uas_params.svh
// constants for the asynchronous serial channel: register indices, field positions,
// reset values and bit-timing counts; included by the rate generator, the top module and the bench
`ifndef UAS_PARAMS_SVH
`define UAS_PARAMS_SVH
// ----------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define UAS_IX_MODE   3'h0
`define UAS_IX_CTRL   3'h1
`define UAS_IX_DIV    3'h2
`define UAS_IX_TXBUF  3'h3
`define UAS_IX_RXBUF  3'h4
`define UAS_IX_STAT   3'h5
// ----------------------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------------------
`define UAS_M_LEN     1:0
`define UAS_M_PEN     2
`define UAS_M_PODD    3
`define UAS_M_STOP2   4
`define UAS_M_EXT     5
`define UAS_M_SRC     7:6
`define UAS_M_SLEEP   8
`define UAS_M_DINV    9
`define UAS_M_PINV    10
`define UAS_M_OD      11
`define UAS_M_FLOW    13:12
`define UAS_M_SPLIT   14
`define UAS_M_TXSEL   15
// ----------------------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------------------
`define UAS_C_TE      0
`define UAS_C_RE      1
`define UAS_S_TBE     0
`define UAS_S_TSE     1
`define UAS_S_RBF     2
`define UAS_S_OVR     3
`define UAS_S_FER     4
`define UAS_S_PER     5
`define UAS_S_SUM     6
// ----------------------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------------------
`define UAS_RST_MODE  16'h0001
`define UAS_RST_DIV   8'h00
`define UAS_PRE8      5'h07
`define UAS_PRE32     5'h1F
`define UAS_OVS_LAST  4'hF
`define UAS_OVS_MID   4'h7
`endif

//--- src/uas_pkg.sv
// types shared by the serial channel modules
// assumes uas_params.svh is on the include path
package uas_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010, TX_PAR = 3'b011, TX_STOP = 3'b100
  } uas_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010, RX_PAR = 3'b011, RX_STOP = 3'b100
  } uas_rx_e;
  typedef enum logic [1:0] {FL_OFF = 2'b00, FL_CTS = 2'b01, FL_RTS = 2'b10, FL_RSV = 2'b11} uas_flow_e;
  // rate generator state
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] cnt;
    logic       ext_d;
    logic       tick;
  } uas_brg_s;
  // channel state
  typedef struct packed {
    logic [15:0] mode;
    logic        te;
    logic        re;
    logic [7:0]  div;
    logic [8:0]  tbuf;
    logic        tbuf_empty;
    logic        tsh_empty;
    uas_tx_e     tx_st;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bit;
    logic [8:0]  tsh;
    logic        tpar;
    uas_rx_e     rx_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [8:0]  rsh;
    logic        rpar;
    logic        rfer;
    logic [8:0]  rbuf;
    logic        rbuf_full;
    logic        ovr;
    logic        fer;
    logic        per;
    logic        esum;
    logic        tx_irq;
    logic        rx_irq;
    logic        wr_pend;
    logic [2:0]  widx;
    logic [31:0] hrdata;
    logic        hready;
    logic        txo;
    logic        txoe_n;
    logic        flo;
    logic        floe_n;
  } uas_top_s;
endpackage

//--- src/uas_brg.sv
// bit-rate generator: sixteen-times sample tick from a count source and 8-bit divider
// assumes the external count clock is synchronous and no faster than half of sys_clk
`include "uas_params.svh"
module uas_brg (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // configuration
  input  wire logic       ext_sel,
  input  wire logic [1:0] src_sel,
  input  wire logic [7:0] div,
  // external count clock pin
  input  wire logic       serial_clock_pin,
  // sixteen-times tick
  output logic            tick16
);
  import uas_pkg::*;
  uas_brg_s st_reg;
  uas_brg_s st_next;
  logic     src_tick;

  // ---------------------------------------------------------------------------
  // count source select and divide by (div + 1)
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.pre   = st_reg.pre + 5'h01;
    st_next.ext_d = serial_clock_pin;
    st_next.tick  = 1'b0;
    if (ext_sel) begin
      src_tick = serial_clock_pin & ~st_reg.ext_d; // rising edge of the external clock RQ5
    end else begin
      case (src_sel) // RQ4
        2'b01:   src_tick = (st_reg.pre[2:0] == 3'(`UAS_PRE8));
        2'b10:   src_tick = (st_reg.pre == `UAS_PRE32);
        default: src_tick = 1'b1;
      endcase
    end
    if (src_tick) begin
      // full 0..255 range: zero divides by one RQ6
      if (st_reg.cnt >= div) begin
        st_next.cnt  = 8'h00;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick16 = st_reg.tick;
endmodule

//--- src/uas_top.sv
// asynchronous serial channel in uart mode with an AHB-Lite register slave
// assumes a single AHB-Lite master, word transfers only, inputs synchronous to sys_clk
//
// Function
// RQ1: frame has one start bit and 7, 8 or 9 character bits.
// RQ2: odd or even parity bit follows the character, or none.
// RQ3: frame ends with one or two stop bits as configured.
// RQ4: undivided, div8 or div32 internal clock divided by 16(n+1) gives the rate.
// RQ5: external clock pin divided by 16(n+1) gives the rate.
// RQ6: divider is 8 bits, any value 0 to 255.
// RQ7: flow pin is clear-to-send input, request-to-send output, or off.
// RQ8: send only with enable, buffer loaded, pin selected, clear-to-send low.
// RQ9: receive only with enable set and a start bit seen.
// RQ10: cause bit clear: transmit request when buffer moves to shifter.
// RQ11: cause bit set: transmit request when shifter finishes the character.
// RQ12: receive request when a character moves into the receive buffer.
// RQ13: overrun when a character completes before the buffer was read.
// RQ14: overrun overwrites the buffer and gives no receive request.
// RQ15: framing error when configured stop bits are not seen.
// RQ16: parity error when ones count disagrees with odd or even setting.
// RQ17: error sum is set whenever any of the three errors is.
// RQ18: data logic switch inverts character bits only.
// RQ19: polarity switch inverts every transmit and receive pin level.
// RQ20: transmit pin idles high, or floats when open drain.
// RQ21: first channel may put clear-to-send and request-to-send on two pins.
// RQ22: sleep mode accepts only characters whose top bit is one.
// RQ23: receiver checks start at mid bit and samples bits at centre.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`include "uas_params.svh"
module uas_top #(
  parameter bit HAS_SPLIT = 1'b1,
  parameter bit HAS_SLEEP = 1'b1,
  parameter bit HAS_DINV  = 1'b1,
  parameter bit HAS_PINV  = 1'b1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // serial pins
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_n,
  input  wire logic        serial_clock_pin,
  input  wire logic        tx_pin_sel,
  // flow-control pins
  input  wire logic        flow_pin_i,
  output logic             flow_pin_o,
  output logic             flow_pin_oe_n,
  input  wire logic        cts_alt_n,
  // request pulses
  output logic             tx_irq,
  output logic             rx_irq
);
  import uas_pkg::*;
  uas_top_s   st_reg;
  uas_top_s   st_next;
  logic       tick;
  logic [3:0] nb;
  logic [8:0] cmask;
  logic [8:0] dmask;
  logic       pinv;
  logic       split;
  logic       cts_en;
  logic       rts_en;
  logic       cts_n;
  logic       tx_load;
  logic       tx_fin;
  logic       rx_fin;
  logic       rx_keep;
  logic       rxl;
  logic       txl;
  logic       acc;
  logic [31:0] rd_val;

  uas_brg u_brg (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .ext_sel          (st_reg.mode[`UAS_M_EXT]),
    .src_sel          (st_reg.mode[`UAS_M_SRC]),
    .div              (st_reg.div),
    .serial_clock_pin (serial_clock_pin),
    .tick16           (tick)
  );

  // ---------------------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------------------
  // length code 0/1/2 gives 7/8/9 bits; code 3 is taken as 9
  assign nb     = (st_reg.mode[`UAS_M_LEN] == 2'h0) ? 4'h7 :
                  (st_reg.mode[`UAS_M_LEN] == 2'h1) ? 4'h8 : 4'h9; // RQ1
  assign cmask  = (nb == 4'h7) ? 9'h07F : (nb == 4'h8) ? 9'h0FF : 9'h1FF;
  assign dmask  = (HAS_DINV && st_reg.mode[`UAS_M_DINV]) ? cmask : 9'h000; // RQ18
  assign pinv   = HAS_PINV && st_reg.mode[`UAS_M_PINV];
  assign split  = HAS_SPLIT && st_reg.mode[`UAS_M_SPLIT]; // RQ21
  assign cts_en = split || (st_reg.mode[`UAS_M_FLOW] == FL_CTS); // RQ7
  assign rts_en = split || (st_reg.mode[`UAS_M_FLOW] == FL_RTS); // RQ7
  assign cts_n  = split ? cts_alt_n : flow_pin_i;
  assign rxl    = serial_in_pin ^ pinv; // RQ19
  assign acc    = hsel && htrans[1] && hready;

  // read data for the address phase
  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[4:2])
      `UAS_IX_MODE:  rd_val[15:0] = st_reg.mode;
      `UAS_IX_CTRL:  rd_val[1:0]  = {st_reg.re, st_reg.te};
      `UAS_IX_DIV:   rd_val[7:0]  = st_reg.div;
      `UAS_IX_TXBUF: rd_val[8:0]  = st_reg.tbuf;
      `UAS_IX_RXBUF: rd_val[8:0]  = st_reg.rbuf ^ dmask; // data inverted on read RQ18
      `UAS_IX_STAT:  rd_val[6:0]  = {st_reg.esum, st_reg.per, st_reg.fer, st_reg.ovr,
                                     st_reg.rbuf_full, st_reg.tsh_empty, st_reg.tbuf_empty};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next-state logic: bus address phase, then transmitter, then write data phase, then receiver
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next        = st_reg;
    st_next.tx_irq = 1'b0;
    st_next.rx_irq = 1'b0;
    tx_load        = 1'b0;
    tx_fin         = 1'b0;
    rx_fin         = 1'b0;
    rx_keep        = 1'b0;
    txl            = 1'b1;
    // address phase: reads answer next cycle, reading the buffer empties it
    st_next.wr_pend = acc && hwrite;
    st_next.widx    = haddr[4:2];
    if (acc && !hwrite) begin
      st_next.hrdata = rd_val;
      if (haddr[4:2] == `UAS_IX_RXBUF) begin
        st_next.rbuf_full = 1'b0;
      end
    end
    // transmitter: load happens before the write so a new write refills the buffer
    if (st_reg.tx_st == TX_IDLE && st_reg.te && !st_reg.tbuf_empty && tx_pin_sel &&
        !(cts_en && cts_n)) begin
      tx_load            = 1'b1; // RQ8
      st_next.tx_st      = TX_START;
      st_next.tx_sub     = 4'h0;
      st_next.tsh        = st_reg.tbuf & cmask;
      st_next.tpar       = (^(st_reg.tbuf & cmask)) ^ st_reg.mode[`UAS_M_PODD]; // RQ2
      st_next.tbuf_empty = 1'b1;
      st_next.tsh_empty  = 1'b0;
      st_next.tx_irq     = !st_reg.mode[`UAS_M_TXSEL]; // RQ10
    end else if (tick && st_reg.tx_st != TX_IDLE) begin
      st_next.tx_sub = st_reg.tx_sub + 4'h1;
      if (st_reg.tx_sub == `UAS_OVS_LAST) begin
        case (st_reg.tx_st)
          TX_START: begin
            st_next.tx_st  = TX_DATA;
            st_next.tx_bit = 4'h0;
          end
          TX_DATA: begin
            if (st_reg.tx_bit == nb - 4'h1) begin
              st_next.tx_st  = st_reg.mode[`UAS_M_PEN] ? TX_PAR : TX_STOP; // RQ2
              st_next.tx_bit = 4'h0;
            end else begin
              st_next.tx_bit = st_reg.tx_bit + 4'h1;
            end
          end
          TX_PAR: begin
            st_next.tx_st  = TX_STOP;
            st_next.tx_bit = 4'h0;
          end
          TX_STOP: begin
            if (st_reg.tx_bit == {3'h0, st_reg.mode[`UAS_M_STOP2]}) begin // RQ3
              tx_fin            = 1'b1;
              st_next.tx_st     = TX_IDLE;
              st_next.tsh_empty = 1'b1;
              st_next.tx_irq    = st_reg.mode[`UAS_M_TXSEL]; // RQ11
            end else begin
              st_next.tx_bit = st_reg.tx_bit + 4'h1;
            end
          end
          default: st_next.tx_st = TX_IDLE;
        endcase
      end
    end
    // data phase of a write
    if (st_reg.wr_pend) begin
      case (st_reg.widx)
        `UAS_IX_MODE: st_next.mode = hwdata[15:0];
        `UAS_IX_CTRL: begin
          st_next.te = hwdata[`UAS_C_TE];
          st_next.re = hwdata[`UAS_C_RE];
        end
        `UAS_IX_DIV:  st_next.div = hwdata[7:0]; // RQ6
        `UAS_IX_TXBUF: begin
          st_next.tbuf       = hwdata[8:0] ^ dmask; // RQ18
          st_next.tbuf_empty = 1'b0;
        end
        `UAS_IX_STAT: begin
          // write one to clear; hardware sets below win
          st_next.ovr = st_reg.ovr & ~hwdata[`UAS_S_OVR];
          st_next.fer = st_reg.fer & ~hwdata[`UAS_S_FER];
          st_next.per = st_reg.per & ~hwdata[`UAS_S_PER];
        end
        default: st_next.mode = st_reg.mode;
      endcase
    end
    // receiver: start validated at mid bit, later bits sampled at centre
    if (st_reg.rx_st == RX_IDLE) begin
      if (rxl) begin
        st_next.rx_bit = 4'h0; // line high again: armed for a falling edge
      end else if (st_reg.re && st_reg.rx_bit == 4'h0) begin // RQ9
        st_next.rx_st  = RX_START;
        st_next.rx_sub = 4'h0;
        st_next.rpar   = 1'b0;
        st_next.rfer   = 1'b0;
      end
    end else if (tick) begin
      st_next.rx_sub = st_reg.rx_sub + 4'h1;
      case (st_reg.rx_st)
        RX_START: begin
          if (rxl) begin
            st_next.rx_st = RX_IDLE; // glitch, not a start bit RQ23
          end else if (st_reg.rx_sub == `UAS_OVS_MID) begin
            st_next.rx_st  = RX_DATA; // RQ23
            st_next.rx_sub = 4'h0;
            st_next.rx_bit = 4'h0;
          end
        end
        RX_DATA: begin
          if (st_reg.rx_sub == `UAS_OVS_LAST) begin
            st_next.rsh[st_reg.rx_bit] = rxl;
            st_next.rpar               = st_reg.rpar ^ rxl;
            if (st_reg.rx_bit == nb - 4'h1) begin
              st_next.rx_st  = st_reg.mode[`UAS_M_PEN] ? RX_PAR : RX_STOP;
              st_next.rx_bit = 4'h0;
            end else begin
              st_next.rx_bit = st_reg.rx_bit + 4'h1;
            end
          end
        end
        RX_PAR: begin
          if (st_reg.rx_sub == `UAS_OVS_LAST) begin
            st_next.rpar  = st_reg.rpar ^ rxl;
            st_next.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (st_reg.rx_sub == `UAS_OVS_LAST) begin
            st_next.rfer = st_reg.rfer | !rxl;
            if (st_reg.rx_bit == {3'h0, st_reg.mode[`UAS_M_STOP2]}) begin
              rx_fin        = 1'b1;
              st_next.rx_st = RX_IDLE;
              st_next.rx_bit = 4'hF; // a low stop bit must rise before a new start
            end else begin
              st_next.rx_bit = st_reg.rx_bit + 4'h1;
            end
          end
        end
        default: st_next.rx_st = RX_IDLE;
      endcase
    end
    // character complete; sleep mode drops characters with a clear top bit
    if (rx_fin) begin
      rx_keep = !(HAS_SLEEP && st_reg.mode[`UAS_M_SLEEP] &&
                  !st_reg.rsh[nb - 4'h1]); // RQ22
    end
    if (rx_keep) begin
      st_next.rbuf = st_reg.rsh & cmask;
      st_next.fer  = st_next.fer | st_reg.rfer | !rxl; // RQ15
      st_next.per  = st_next.per | (st_reg.mode[`UAS_M_PEN] &&
                     (st_reg.rpar != st_reg.mode[`UAS_M_PODD])); // RQ16
      if (st_next.rbuf_full) begin
        st_next.ovr = 1'b1; // RQ13 RQ14
      end else begin
        st_next.rx_irq = 1'b1; // RQ12
      end
      st_next.rbuf_full = 1'b1;
    end
    st_next.esum = st_next.ovr | st_next.fer | st_next.per; // RQ17
    // line level from the next state, so the pin follows the state flop
    case (st_next.tx_st)
      TX_START: txl = 1'b0;
      TX_DATA:  txl = st_next.tsh[st_next.tx_bit]; // RQ1
      TX_PAR:   txl = st_next.tpar;
      default:  txl = 1'b1; // idle and stop bits high RQ20 RQ3
    endcase
    st_next.txo    = txl ^ (HAS_PINV && st_next.mode[`UAS_M_PINV]); // next mode: no lag RQ19
    st_next.txoe_n = st_next.mode[`UAS_M_OD] & st_next.txo; // open drain floats RQ20
    // request-to-send low while the receiver can take a character
    st_next.flo    = !(st_next.re && !st_next.rbuf_full) || !rts_en; // RQ7
    st_next.floe_n = !rts_en;
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg            <= '0;
      st_reg.mode       <= `UAS_RST_MODE;
      st_reg.div        <= `UAS_RST_DIV;
      st_reg.tbuf_empty <= 1'b1;
      st_reg.tsh_empty  <= 1'b1;
      st_reg.hready     <= 1'b1;
      st_reg.txo        <= 1'b1;
      st_reg.flo        <= 1'b1;
      st_reg.floe_n     <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs from the state register; hresp tied low
  // ---------------------------------------------------------------------------
  assign hreadyout           = st_reg.hready;
  assign hresp               = 1'b0;
  assign hrdata              = st_reg.hrdata;
  assign serial_out_pin_o    = st_reg.txo;
  assign serial_out_pin_oe_n = st_reg.txoe_n;
  assign flow_pin_o          = st_reg.flo;
  assign flow_pin_oe_n       = st_reg.floe_n;
  assign tx_irq              = st_reg.tx_irq;
  assign rx_irq              = st_reg.rx_irq;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_tx_start;
    $rose(st_reg.tx_st == TX_START) |->
      $past(st_reg.te && tx_pin_sel && !st_reg.tbuf_empty && !(cts_en && cts_n));
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit started without conditions"); // RQ8

  property p_rx_start;
    (st_reg.rx_st == RX_IDLE && !(st_reg.re && !rxl)) |=> st_reg.rx_st == RX_IDLE;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("receive started without enable"); // RQ9

  property p_txirq_load;
    tx_load |=> (tx_irq == !$past(st_reg.mode[`UAS_M_TXSEL])) && st_reg.tx_st == TX_START;
  endproperty
  a_txirq_load: assert property (p_txirq_load) else $error("wrong transmit request on load"); // RQ10

  property p_txirq_fin;
    tx_fin && st_reg.mode[`UAS_M_TXSEL] |=> tx_irq && st_reg.tsh_empty;
  endproperty
  a_txirq_fin: assert property (p_txirq_fin) else $error("missing transmit-done request"); // RQ11

  property p_ovr;
    rx_keep && st_reg.rbuf_full && !(acc && !hwrite && haddr[4:2] == `UAS_IX_RXBUF)
      |=> st_reg.ovr && !rx_irq && st_reg.rbuf == $past(st_reg.rsh & cmask);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not handled"); // RQ13 RQ14

  property p_rxirq;
    rx_irq |-> st_reg.rbuf_full && $past(st_reg.rx_st == RX_STOP);
  endproperty
  a_rxirq: assert property (p_rxirq) else $error("receive request without character"); // RQ12

  property p_sum;
    ##1 st_reg.esum == (st_reg.ovr | st_reg.fer | st_reg.per);
  endproperty
  a_sum: assert property (p_sum) else $error("error sum mismatch"); // RQ17

  property p_idle_pin;
    $past(st_reg.tx_st == TX_IDLE) && st_reg.tx_st == TX_IDLE
      |-> serial_out_pin_o == !pinv && serial_out_pin_oe_n == (st_reg.mode[`UAS_M_OD] && !pinv);
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("idle transmit pin level wrong"); // RQ20 RQ19

  property p_start_bit;
    st_reg.tx_st == TX_START |-> serial_out_pin_o == pinv;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit level wrong"); // RQ1

  property p_sleep;
    rx_fin && HAS_SLEEP && st_reg.mode[`UAS_M_SLEEP] && !st_reg.rsh[nb - 4'h1]
      |=> !rx_irq && $stable(st_reg.rbuf);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep mode accepted a character"); // RQ22

  c_tx_done: cover property (tx_fin);
  c_rx_done: cover property (rx_keep && !st_reg.rbuf_full);
  c_overrun: cover property ($rose(st_reg.ovr));
  c_par_err: cover property ($rose(st_reg.per));
endmodule

//--- bench/uas_remote.sv
// remote serial device standing on the transmit and receive lines
// assumes both lines idle high and one bit cell lasts BIT_CYC sys_clk cycles
module uas_remote #(
  parameter int BIT_CYC = 32
) (
  // clock
  input  wire logic sys_clk,
  // serial lines
  input  wire logic line_in,
  output logic      line_out
);
  int rx_q[$];
  int nb = 8;
  bit pen;
  bit podd;
  bit stop2;
  initial line_out = 1'b1;
  // one cell, changed just after an edge
  task automatic put(input logic b);
    line_out <= b;
    repeat (BIT_CYC) @(posedge sys_clk);
  endtask
  // a bad stop is driven low, then the line is released high again
  task automatic send(input int d, input bit bad_par, input bit bad_stop);
    @(posedge sys_clk);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (pen) put(^(d & ((1 << nb) - 1)) ^ podd ^ bad_par);
    put(!bad_stop);
    if (stop2 || bad_stop) put(1'b1);
  endtask
  // sample each cell at its centre, queue all bits after the start bit
  always @(negedge line_in) begin : rx
    int v;
    v = 0;
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < nb + pen + 1 + stop2; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      v[i] = line_in;
    end
    rx_q.push_back(v);
  end
endmodule

//--- bench/async_serial_uart_mode_tb_top.sv
// self-checking bench: registers over AHB-Lite, frames against the remote model
// assumes one bit is 32 sys_clk cycles: divider 1 on the undivided source, or divider 0
// on an external count clock of half the sys_clk rate
`include "uas_params.svh"
module async_serial_uart_mode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, xclk = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hready, hresp, txo, txoe_n, txd, rxd, flo, floe_n, tx_irq, rx_irq;
  int          failures = 0, n_checks = 0, n_tx = 0, n_rx = 0;
  always #25 sys_clk = ~sys_clk;
  // external count clock from the far side, half the sys_clk rate
  always @(posedge sys_clk) xclk <= ~xclk;
  // request pulses last one cycle, so count them at every edge
  always @(posedge sys_clk) begin
    n_tx += int'(tx_irq === 1'b1);
    n_rx += int'(rx_irq === 1'b1);
  end
  // open-drain release reads as the pull-up level
  assign txd = txoe_n ? 1'b1 : txo;
  // clear-to-send held low by the far side
  uas_top i_uas_top (
    .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .serial_in_pin(rxd), .serial_out_pin_o(txo),
    .serial_out_pin_oe_n(txoe_n), .serial_clock_pin(xclk), .tx_pin_sel(1'b1),
    .flow_pin_i(1'b0), .flow_pin_o(flo), .flow_pin_oe_n(floe_n), .cts_alt_n(1'b0),
    .tx_irq, .rx_irq
  );
  uas_remote #(.BIT_CYC(32)) i_uas_remote (.sys_clk, .line_in(txd), .line_out(rxd));
  // ----------------------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo();
    failures++;
    wrap_up();
  endtask
  // one single transfer; entered just after a rising edge
  task automatic bus(input logic [2:0] ix, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    haddr <= {27'h0, ix, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge sys_clk);
      k++;
    end while (hready !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) tmo();
  endtask
  task automatic rchk(input string what, input logic [2:0] ix, input logic [31:0] exp);
    bus(ix, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask
  task automatic wait_rbf();
    for (int k = 0; k < 600; k++) begin
      bus(`UAS_IX_STAT, 1'b0, 32'h0);
      if (rd[`UAS_S_RBF] === 1'b1) return;
    end
    tmo();
  endtask
  // frame bits after the start bit: character, parity, stops
  function automatic int frame(input int d, input int nb, input bit pen, podd, stop2);
    int v;
    v = d & ((1 << nb) - 1);
    if (pen) v |= int'(^v ^ podd) << nb;
    v |= (stop2 ? 3 : 1) << (nb + int'(pen));
    return v;
  endfunction
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    int m_t[4] = '{32'h0001, 32'h8016, 32'h000C, 32'h0221};
    int s_t[3] = '{32'h67, 32'h57, 32'h4F};
    int d, tx0, rx0, x;
    void'($urandom(53427));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    hsel <= 1'b1;
    @(posedge sys_clk);
    chk("idle pin", 32'h1, {31'h0, txd});
    chk("okay", 32'h0, {31'h0, hresp});
    rchk("mode", `UAS_IX_MODE, 32'h1);
    rchk("status", `UAS_IX_STAT, 32'h3);
    rchk("unmapped", 3'h6, 32'h0);
    bus(`UAS_IX_DIV, 1'b1, 32'h1);
    bus(`UAS_IX_CTRL, 1'b1, 32'h3);
    // each format: one character out, one in
    foreach (m_t[m]) begin
      if (m_t[m][5]) bus(`UAS_IX_DIV, 1'b1, 32'h0);
      bus(`UAS_IX_MODE, 1'b1, m_t[m]);
      i_uas_remote.nb = 7 + m_t[m][1:0];
      {i_uas_remote.stop2, i_uas_remote.podd, i_uas_remote.pen} = m_t[m][4:2];
      d = $urandom & 32'h1FF;
      x = m_t[m][9] ? 32'h1FF : 32'h0;
      tx0 = n_tx;
      rx0 = n_rx;
      bus(`UAS_IX_TXBUF, 1'b1, d);
      for (int k = 0; k < 900 && i_uas_remote.rx_q.size() == 0; k++) @(posedge sys_clk);
      if (i_uas_remote.rx_q.size() == 0) tmo();
      chk("tx frame", frame(d ^ x, i_uas_remote.nb, m_t[m][2], m_t[m][3], m_t[m][4]),
          i_uas_remote.rx_q.pop_front());
      chk("tx irq early", {31'h0, !m_t[m][15]}, n_tx - tx0);
      i_uas_remote.send(d ^ 32'h155, 1'b0, 1'b0);
      wait_rbf();
      rchk("rx data", `UAS_IX_RXBUF, (d ^ 32'h155 ^ x) & ((1 << i_uas_remote.nb) - 1));
      chk("tx irq", 32'h1, n_tx - tx0);
      chk("rx irq", 32'h1, n_rx - rx0);
    end
    // parity error, framing error, overrun; 8 bits, odd parity
    bus(`UAS_IX_MODE, 1'b1, 32'h002D);
    {i_uas_remote.nb, i_uas_remote.pen, i_uas_remote.podd, i_uas_remote.stop2} = {32'd8, 3'b110};
    for (int e = 0; e < 3; e++) begin
      rx0 = n_rx;
      i_uas_remote.send(32'h5A, e == 0, e == 1);
      if (e == 2) i_uas_remote.send(32'hA5, 1'b0, 1'b0);
      wait_rbf();
      chk("errors", s_t[e], rd);
      rchk("rx buffer", `UAS_IX_RXBUF, (e == 2) ? 32'hA5 : 32'h5A);
      chk("rx irq", 32'h1, n_rx - rx0);
      bus(`UAS_IX_STAT, 1'b1, 32'h38);
      rchk("cleared", `UAS_IX_STAT, 32'h3);
    end
    // polarity inverted idle line and request-to-send asserted
    bus(`UAS_IX_MODE, 1'b1, 32'h2421);
    repeat (2) @(posedge sys_clk);
    chk("inverted idle", 32'h0, {31'h0, txd});
    chk("rts", 32'h0, {30'h0, flo, floe_n});
    wrap_up();
  end
endmodule
